/* File: logic/dcps_defines.svh */
// Offsets, field positions, reset values and timing counts of the drive command block.
// Assumes a 20 MHz control clock; included by its bare name.
`ifndef DCPS_DEFINES_SVH
`define DCPS_DEFINES_SVH
// Register offsets (word index on the plain register port)
`define DCPS_OFS_DI_FUNC0 8'h00
`define DCPS_OFS_DI_FUNC7 8'h07
`define DCPS_OFS_HALT_TIME 8'h08
`define DCPS_OFS_AO1_SRC 8'h09
`define DCPS_OFS_AO1_GAIN 8'h0A
`define DCPS_OFS_AO1_BIAS 8'h0B
`define DCPS_OFS_AO2_SRC 8'h0C
`define DCPS_OFS_AO2_GAIN 8'h0D
`define DCPS_OFS_AO2_BIAS 8'h0E
`define DCPS_OFS_AO2_TYPE 8'h0F
`define DCPS_OFS_PID_MODE 8'h10
`define DCPS_OFS_PID_KP 8'h11
`define DCPS_OFS_PID_TI 8'h12
`define DCPS_OFS_FB_TYPE 8'h13
`define DCPS_OFS_SP_SCALE 8'h14
`define DCPS_OFS_SP_UNIT 8'h15
`define DCPS_OFS_SETPOINT 8'h16
`define DCPS_OFS_FEEDBACK 8'h17
`define DCPS_OFS_SEL_DATA 8'h18
`define DCPS_OFS_STATUS 8'h19
`define DCPS_OFS_PID_OUT 8'h1A
`define DCPS_OFS_FREQ 8'h1B
`define DCPS_OFS_SP_DISP 8'h1C
// Digital input function codes
`define DCPS_FN_JOG_FWD 8'h06
`define DCPS_FN_JOG_REV 8'h07
`define DCPS_FN_HALT 8'h0E
`define DCPS_FN_GUARD 8'h32
// Mode bit positions
`define DCPS_MODE_EN 0
`define DCPS_MODE_NEG 1
`define DCPS_MODE_DFB 2
`define DCPS_MODE_ADD 3
// Analog source codes
`define DCPS_SRC_MAX 5'h1C
`define DCPS_FB_VOLT 2'h1
`define DCPS_FB_CURR 2'h2
// Reset values (gain in 0.1 %, bias in 0.1 %, halt time in 0.1 s, integral time in 0.1 ms)
`define DCPS_RST_GAIN 16'h03E8
`define DCPS_RST_KP 16'h000A
`define DCPS_RST_TI 16'h000A
`define DCPS_RST_HALT 16'h0032
`define DCPS_RST_SCALE 16'h2EE0
// Timing: one tenth of a second at 20 MHz
`define DCPS_CLK_HZ 20000000
`define DCPS_TENTH_CYC (`DCPS_CLK_HZ / 10)
`define DCPS_FREQ_MAX 16'h7FFF
`endif

/* File: logic/dcps_pkg.sv */
// Types shared by the drive command block.
// Assumes nothing beyond a SystemVerilog compiler.
package dcps_pkg;
  typedef enum logic [1:0] {DCPS_IDLE, DCPS_RUN, DCPS_HALT, DCPS_LOCK} dcps_state_type;
endpackage

/* File: logic/dcps_analog_out.sv */
// One analog output channel: picks a source, applies gain and bias.
// Assumes sources are signed 16-bit with 16'h4000 as 100 percent.
`timescale 1ns/1ps
`include "dcps_defines.svh"
module dcps_analog_out (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] src_sel,
  input wire logic [15:0] gain,
  input wire logic [15:0] bias,
  input wire logic [463:0] sources,
  output logic [15:0] level_q
);
  logic [15:0] pick;
  logic signed [33:0] scaled;
  logic signed [33:0] biased;
  logic [15:0] level_d;
  // Reserved or out-of-range codes give zero
  assign pick = (src_sel > `DCPS_SRC_MAX || src_sel == 5'h0E || src_sel == 5'h10 || src_sel == 5'h13 ||
                 src_sel == 5'h14) ? 16'h0000 : sources[src_sel*16 +: 16];
  // 100 percent of the quantity at gain 100.0 percent reaches full scale (four times 16'h4000)
  assign scaled = ($signed({{18{pick[15]}}, pick}) * $signed({18'h00000, gain})) / 34'sd250;
  // Bias of 100 percent shifts the zero level by full scale
  assign biased = scaled + (($signed({{18{bias[15]}}, bias}) * 34'sd65536) / 34'sd1000);
  assign level_d = (biased < 0) ? 16'h0000 : (biased > 34'sd65535) ? 16'hFFFF : biased[15:0];
  // Output register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) level_q <= 16'h0000;
    else level_q <= level_d;
  end
endmodule

/* File: logic/dcps_ramp.sv */
// Frequency ramp: moves the output toward a target in set time steps.
// Assumes a tick of one tenth of a second from the caller.
`timescale 1ns/1ps
`include "dcps_defines.svh"
module dcps_ramp (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] target,
  input wire logic [15:0] step,
  input wire logic tick,
  output logic [15:0] freq_q
);
  logic [15:0] freq_d;
  logic [16:0] up;
  assign up = {1'b0, freq_q} + {1'b0, step};
  // Saturating move toward the target on each tick
  assign freq_d = !tick ? freq_q :
                  (freq_q < target) ? ((up[15:0] > target || up[16]) ? target : up[15:0]) :
                  ((freq_q - target) < step) ? target : freq_q - step;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) freq_q <= 16'h0000;
    else freq_q <= freq_d;
  end
endmodule

/* File: logic/dcps_top.sv */
// Drive command and process regulator: input functions, halt, guard, analog outputs, PID.
// Assumes pins asynchronous to CLOCK; registers on a plain one-cycle port.
`timescale 1ns/1ps
`include "dcps_defines.svh"
// What this block does
// - Halt input ramps motor to zero with halt time and shows halt indication
// - Halt ends only after run request gone and halt input released
// - Function code 6 jogs forward, code 7 jogs reverse
// - With guard function set, a run request present at power-up is refused
// - Each analog output selects source 0 to 28; 14,16,19,20 reserved
// - Gain 0 to 1000 percent scales output; full scale is 100 percent
// - Bias -100 to 100 percent offsets output zero level
// - Second output type: 0 voltage, 1 current; board switch must agree
// - Error is setpoint minus feedback, multiplied by proportional gain
// - Integral time sets integral rate; longer time responds slower
// - Mode bit 0 enables the regulator
// - Mode bit 1 reverses direction of action
// - Mode bit 2 applies derivative to error or to feedback
// - Mode bit 3 adds the target value to the regulator result
// - Feedback type 2 is current, 1 is voltage; switch must match
// - Setpoint display scaled from decimals-and-range setting; unit setting is stored but not used
module dcps_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] DIGITAL_INPUTS,
  input wire logic RUN_FWD,
  input wire logic RUN_REV,
  input wire logic ANALOG_OUT_TYPE_SWITCH,
  input wire logic FEEDBACK_TYPE_SWITCH,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic EMERGENCY_HALT_INDICATION,
  output logic UNATTENDED_START_GUARD,
  output logic MOTOR_RUN,
  output logic MOTOR_REVERSE,
  output logic [15:0] OUTPUT_FREQ,
  output logic [15:0] ANALOG_OUT_FIRST,
  output logic [15:0] ANALOG_OUT_SECOND,
  output logic ANALOG_OUT_SECOND_CURRENT,
  output logic TYPE_MISMATCH
);
  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [9:0] pin_s1_q;
  logic [9:0] pin_s2_q;
  logic [1:0] sw_s1_q;
  logic [1:0] sw_s2_q;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pin_s1_q <= 10'h000;
      pin_s2_q <= 10'h000;
      sw_s1_q <= 2'h0;
      sw_s2_q <= 2'h0;
    end else begin
      pin_s1_q <= {RUN_REV, RUN_FWD, DIGITAL_INPUTS};
      pin_s2_q <= pin_s1_q;
      sw_s1_q <= {FEEDBACK_TYPE_SWITCH, ANALOG_OUT_TYPE_SWITCH};
      sw_s2_q <= sw_s1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Settings registers
  logic [7:0] di_func_q [0:7];
  logic [15:0] halt_time_q, ao1_gain_q, ao1_bias_q, ao2_gain_q, ao2_bias_q, kp_q, ti_q;
  logic [15:0] sp_scale_q, setpoint_q, feedback_q, sel_data_q;
  logic [4:0] ao1_src_q, ao2_src_q;
  logic [3:0] pid_mode_q, sp_unit_q;
  logic [1:0] fb_type_q;
  logic ao2_type_q;
  // Write decode for each setting
  wire wr_func = WR && (ADDR <= `DCPS_OFS_DI_FUNC7);
  wire wr_halt = WR && (ADDR == `DCPS_OFS_HALT_TIME);
  wire wr_a1s = WR && (ADDR == `DCPS_OFS_AO1_SRC);
  wire wr_a1g = WR && (ADDR == `DCPS_OFS_AO1_GAIN);
  wire wr_a1b = WR && (ADDR == `DCPS_OFS_AO1_BIAS);
  wire wr_a2s = WR && (ADDR == `DCPS_OFS_AO2_SRC);
  wire wr_a2g = WR && (ADDR == `DCPS_OFS_AO2_GAIN);
  wire wr_a2b = WR && (ADDR == `DCPS_OFS_AO2_BIAS);
  wire wr_a2t = WR && (ADDR == `DCPS_OFS_AO2_TYPE);
  wire wr_mode = WR && (ADDR == `DCPS_OFS_PID_MODE);
  wire wr_kp = WR && (ADDR == `DCPS_OFS_PID_KP);
  wire wr_ti = WR && (ADDR == `DCPS_OFS_PID_TI);
  wire wr_fbt = WR && (ADDR == `DCPS_OFS_FB_TYPE);
  wire wr_scl = WR && (ADDR == `DCPS_OFS_SP_SCALE);
  wire wr_unit = WR && (ADDR == `DCPS_OFS_SP_UNIT);
  wire wr_sp = WR && (ADDR == `DCPS_OFS_SETPOINT);
  wire wr_fb = WR && (ADDR == `DCPS_OFS_FEEDBACK);
  wire wr_sel = WR && (ADDR == `DCPS_OFS_SEL_DATA);
  // Setting storage
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) di_func_q[i] <= 8'h00;
      halt_time_q <= `DCPS_RST_HALT;
      ao1_src_q <= 5'h00;
      ao2_src_q <= 5'h00;
      ao1_gain_q <= `DCPS_RST_GAIN;
      ao2_gain_q <= `DCPS_RST_GAIN;
      ao1_bias_q <= 16'h0000;
      ao2_bias_q <= 16'h0000;
      ao2_type_q <= 1'b0;
      pid_mode_q <= 4'h0;
      kp_q <= `DCPS_RST_KP;
      ti_q <= `DCPS_RST_TI;
      fb_type_q <= `DCPS_FB_VOLT;
      sp_scale_q <= `DCPS_RST_SCALE;
      sp_unit_q <= 4'h0;
      setpoint_q <= 16'h0000;
      feedback_q <= 16'h0000;
      sel_data_q <= 16'h0000;
    end else begin
      if (wr_func) di_func_q[ADDR[2:0]] <= WDATA[7:0];
      if (wr_halt) halt_time_q <= WDATA;
      if (wr_a1s) ao1_src_q <= WDATA[4:0];
      if (wr_a1g) ao1_gain_q <= WDATA;
      if (wr_a1b) ao1_bias_q <= WDATA;
      if (wr_a2s) ao2_src_q <= WDATA[4:0];
      if (wr_a2g) ao2_gain_q <= WDATA;
      if (wr_a2b) ao2_bias_q <= WDATA;
      if (wr_a2t) ao2_type_q <= WDATA[0];
      if (wr_mode) pid_mode_q <= WDATA[3:0];
      if (wr_kp) kp_q <= WDATA;
      if (wr_ti) ti_q <= WDATA;
      if (wr_fbt) fb_type_q <= WDATA[1:0];
      if (wr_scl) sp_scale_q <= WDATA;
      if (wr_unit) sp_unit_q <= WDATA[3:0];
      if (wr_sp) setpoint_q <= WDATA;
      if (wr_fb) feedback_q <= WDATA;
      if (wr_sel) sel_data_q <= WDATA;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Input function mapping
  logic [7:0] fn_halt, fn_jf, fn_jr, fn_guard;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_fn
      assign fn_halt[g] = (di_func_q[g] == `DCPS_FN_HALT) && pin_s2_q[g];
      assign fn_jf[g] = (di_func_q[g] == `DCPS_FN_JOG_FWD) && pin_s2_q[g];
      assign fn_jr[g] = (di_func_q[g] == `DCPS_FN_JOG_REV) && pin_s2_q[g];
      assign fn_guard[g] = (di_func_q[g] == `DCPS_FN_GUARD);
    end
  endgenerate
  wire halt_in = |fn_halt;
  wire jog_fwd = |fn_jf;
  wire jog_rev = |fn_jr;
  wire guard_on = |fn_guard;
  wire run_req = pin_s2_q[8] || pin_s2_q[9];
  wire any_req = run_req || jog_fwd || jog_rev;
  ////////////////////////////////////////////////////////////////////////////////
  // Run control state machine
  dcps_pkg::dcps_state_type st_q, st_d;
  logic boot_q, dir_q, dir_d;
  always_comb begin
    st_d = st_q;
    dir_d = dir_q;
    case (st_q)
      dcps_pkg::DCPS_IDLE: begin
        if (halt_in) st_d = dcps_pkg::DCPS_HALT;
        else if (boot_cnt_q != 2'h3) st_d = dcps_pkg::DCPS_IDLE;
        else if (boot_q && guard_on && run_req) st_d = dcps_pkg::DCPS_LOCK;
        else if (any_req) begin
          st_d = dcps_pkg::DCPS_RUN;
          dir_d = pin_s2_q[9] || (jog_rev && !pin_s2_q[8]);
        end
      end
      dcps_pkg::DCPS_RUN: begin
        if (halt_in) st_d = dcps_pkg::DCPS_HALT;
        else if (!any_req) st_d = dcps_pkg::DCPS_IDLE;
        else dir_d = pin_s2_q[9] || (jog_rev && !pin_s2_q[8]);
      end
      // Requests ignored until run removed and halt released
      dcps_pkg::DCPS_HALT: if (!halt_in && !any_req) st_d = dcps_pkg::DCPS_IDLE;
      // Guard lock clears once the run request goes away
      dcps_pkg::DCPS_LOCK: if (!run_req) st_d = dcps_pkg::DCPS_IDLE;
      default: st_d = dcps_pkg::DCPS_IDLE;
    endcase
  end
  // State and power-up window; boot_q marks a run request held since power-up
  logic [1:0] boot_cnt_q;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_q <= dcps_pkg::DCPS_IDLE;
      dir_q <= 1'b0;
      boot_cnt_q <= 2'h0;
      boot_q <= 1'b1;
    end else begin
      st_q <= st_d;
      dir_q <= dir_d;
      boot_cnt_q <= (boot_cnt_q == 2'h3) ? boot_cnt_q : boot_cnt_q + 2'h1;
      boot_q <= boot_q && (run_req || boot_cnt_q < 2'h2);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Process regulator
  logic signed [31:0] integ_q;
  logic [15:0] prev_d_q;
  logic [31:0] ti_cnt_q;
  logic [15:0] pid_out_q;
  wire signed [16:0] err_raw = $signed({1'b0, setpoint_q}) - $signed({1'b0, feedback_q});
  wire signed [16:0] err = pid_mode_q[`DCPS_MODE_NEG] ? -err_raw : err_raw;
  wire signed [33:0] p_term = (err * $signed({1'b0, kp_q})) / 34'sd10;
  wire [15:0] d_src = pid_mode_q[`DCPS_MODE_DFB] ? feedback_q : err[15:0];
  wire signed [16:0] d_term = $signed({1'b0, d_src}) - $signed({1'b0, prev_d_q});
  wire signed [16:0] d_sign = pid_mode_q[`DCPS_MODE_DFB] ? -d_term : d_term;
  wire signed [33:0] pid_sum = p_term + 34'(integ_q) + 34'(d_sign);
  wire signed [33:0] pid_tot = pid_mode_q[`DCPS_MODE_ADD] ? pid_sum + $signed({18'h00000, setpoint_q}) : pid_sum;
  wire [15:0] pid_clip = (pid_tot < 0) ? 16'h0000 : (pid_tot > 34'sd32767) ? `DCPS_FREQ_MAX : pid_tot[15:0];
  // Integral step once per integral time unit: longer time accumulates slower
  wire ti_tick = ({32'h00000000, ti_cnt_q} >= (64'(`DCPS_TENTH_CYC) * 64'(ti_q)) / 64'd1000);
  wire pid_en = pid_mode_q[`DCPS_MODE_EN];
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      integ_q <= 32'sh00000000;
      prev_d_q <= 16'h0000;
      ti_cnt_q <= 32'h00000000;
      pid_out_q <= 16'h0000;
    end else if (!pid_en) begin
      integ_q <= 32'sh00000000;
      ti_cnt_q <= 32'h00000000;
      prev_d_q <= d_src;
      pid_out_q <= 16'h0000;
    end else begin
      ti_cnt_q <= ti_tick ? 32'h00000000 : ti_cnt_q + 32'h00000001;
      if (ti_tick) integ_q <= integ_q + 32'(err);
      prev_d_q <= d_src;
      pid_out_q <= pid_clip;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Ramp and frequency target; halt uses its own ramp time
  logic [21:0] tenth_q;
  wire tick = (tenth_q == 22'(`DCPS_TENTH_CYC - 1));
  wire halting = (st_q == dcps_pkg::DCPS_HALT);
  wire running = (st_q == dcps_pkg::DCPS_RUN);
  wire [15:0] base_freq = pid_en ? pid_out_q : sel_data_q;
  wire [15:0] target = running ? base_freq : 16'h0000;
  wire [15:0] halt_step = (halt_time_q == 16'h0000) ? `DCPS_FREQ_MAX : `DCPS_FREQ_MAX / halt_time_q;
  wire [15:0] ramp_step = halting ? halt_step : 16'h0100;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) tenth_q <= 22'h000000;
    else tenth_q <= tick ? 22'h000000 : tenth_q + 22'h000001;
  end
  logic [15:0] freq;
  dcps_ramp u_ramp (
    .clk(CLOCK),
    .rst(RST),
    .target(target),
    .step(ramp_step),
    .tick(tick || (halting && halt_time_q == 16'h0000)),
    .freq_q(freq)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Analog outputs
  wire [463:0] sources = {64'h0, feedback_q, setpoint_q, pid_out_q, err[15:0], 304'h0, freq, freq};
  dcps_analog_out u_ao1 (
    .clk(CLOCK),
    .rst(RST),
    .src_sel(ao1_src_q),
    .gain(ao1_gain_q),
    .bias(ao1_bias_q),
    .sources(sources),
    .level_q(ANALOG_OUT_FIRST)
  );
  dcps_analog_out u_ao2 (
    .clk(CLOCK),
    .rst(RST),
    .src_sel(ao2_src_q),
    .gain(ao2_gain_q),
    .bias(ao2_bias_q),
    .sources(sources),
    .level_q(ANALOG_OUT_SECOND)
  );
  // Setpoint display value: value times scale range over 100 percent
  wire [31:0] sp_disp = (32'(setpoint_q) * 32'(sp_scale_q)) >> 14;
  // Type mismatches between settings and board switches
  wire fb_curr = (fb_type_q == `DCPS_FB_CURR);
  wire mism = (ao2_type_q != sw_s2_q[0]) || (fb_curr != sw_s2_q[1]);
  ////////////////////////////////////////////////////////////////////////////////
  // Read data and status outputs
  wire [15:0] status = {11'h000, mism, dir_q, running, st_q == dcps_pkg::DCPS_LOCK, halting};
  wire [15:0] rd_mux = (ADDR <= `DCPS_OFS_DI_FUNC7) ? {8'h00, di_func_q[ADDR[2:0]]} :
                       (ADDR == `DCPS_OFS_HALT_TIME) ? halt_time_q :
                       (ADDR == `DCPS_OFS_AO1_GAIN) ? ao1_gain_q :
                       (ADDR == `DCPS_OFS_PID_MODE) ? {12'h000, pid_mode_q} :
                       (ADDR == `DCPS_OFS_PID_KP) ? kp_q :
                       (ADDR == `DCPS_OFS_PID_TI) ? ti_q :
                       (ADDR == `DCPS_OFS_STATUS) ? status :
                       (ADDR == `DCPS_OFS_PID_OUT) ? pid_out_q :
                       (ADDR == `DCPS_OFS_FREQ) ? freq :
                       (ADDR == `DCPS_OFS_SP_DISP) ? sp_disp[15:0] : 16'h0000;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RDATA <= 16'h0000;
      EMERGENCY_HALT_INDICATION <= 1'b0;
      UNATTENDED_START_GUARD <= 1'b0;
      MOTOR_RUN <= 1'b0;
      MOTOR_REVERSE <= 1'b0;
      OUTPUT_FREQ <= 16'h0000;
      ANALOG_OUT_SECOND_CURRENT <= 1'b0;
      TYPE_MISMATCH <= 1'b0;
    end else begin
      RDATA <= RD ? rd_mux : 16'h0000;
      EMERGENCY_HALT_INDICATION <= halting;
      UNATTENDED_START_GUARD <= (st_q == dcps_pkg::DCPS_LOCK);
      MOTOR_RUN <= running || (freq != 16'h0000);
      MOTOR_REVERSE <= dir_q;
      OUTPUT_FREQ <= freq;
      ANALOG_OUT_SECOND_CURRENT <= ao2_type_q;
      TYPE_MISMATCH <= mism;
    end
  end
endmodule

/* File: bench/dcps_top_asserts.sv */
// Port checker for the drive command block: bus answer, halt, guard and type agreement.
// Assumes binding to dcps_top; sees only its ports.
`timescale 1ns/1ps
`include "dcps_defines.svh"
module dcps_top_asserts (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic RUN_FWD,
  input wire logic RUN_REV,
  input wire logic ANALOG_OUT_TYPE_SWITCH,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic EMERGENCY_HALT_INDICATION,
  input wire logic UNATTENDED_START_GUARD,
  input wire logic MOTOR_RUN,
  input wire logic [15:0] OUTPUT_FREQ,
  input wire logic ANALOG_OUT_SECOND_CURRENT,
  input wire logic TYPE_MISMATCH
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  // Read data only in the cycle after a read strobe
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside its answer cycle");
  // Halted output frequency never rises
  a_halt_ramp_down: assert property (EMERGENCY_HALT_INDICATION && $past(EMERGENCY_HALT_INDICATION)
    |-> OUTPUT_FREQ <= $past(OUTPUT_FREQ)) else $error("frequency rose while halted");
  // Halt ends only with the run request gone
  a_halt_exit_cond: assert property ($fell(EMERGENCY_HALT_INDICATION) |-> !RUN_FWD && !RUN_REV
    && $past(!RUN_FWD && !RUN_REV, 2)) else $error("halt left with run request present");
  // Halted at zero frequency the motor is off
  a_halt_no_run: assert property (EMERGENCY_HALT_INDICATION && $past(EMERGENCY_HALT_INDICATION)
    && $past(OUTPUT_FREQ) == 16'h0000 |-> !MOTOR_RUN) else $error("motor runs while halted");
  // Locked start keeps the motor off
  a_guard_no_run: assert property (UNATTENDED_START_GUARD && $past(UNATTENDED_START_GUARD)
    |-> !MOTOR_RUN && OUTPUT_FREQ == 16'h0000) else $error("motor runs while locked");
  // Lock released only once run request is gone
  a_guard_exit_cond: assert property ($fell(UNATTENDED_START_GUARD) |-> !RUN_FWD && !RUN_REV)
    else $error("lock left with run request present");
  // Halt and lock never together
  a_state_exclusive: assert property (!(EMERGENCY_HALT_INDICATION && UNATTENDED_START_GUARD))
    else $error("halt and lock both shown");
  // Frequency stays within its ceiling
  a_freq_ceiling: assert property (OUTPUT_FREQ <= `DCPS_FREQ_MAX)
    else $error("frequency above ceiling");
  // Output type against board switch
  a_ao2_type_agree: assert property ((ANALOG_OUT_SECOND_CURRENT != ANALOG_OUT_TYPE_SWITCH)[*4]
    |-> TYPE_MISMATCH) else $error("type disagreement not flagged");
  // Main scenarios reached
  c_halt_entry: cover property ($rose(EMERGENCY_HALT_INDICATION));
  c_guard_entry: cover property ($rose(UNATTENDED_START_GUARD));
  c_mismatch: cover property ($rose(TYPE_MISMATCH));
endmodule

/* File: bench/dcps_field_model.sv */
// Field side model: board switches and a motor that follows the run output.
// Assumes the bench names the wanted switch positions; switches settle one edge later.
`timescale 1ns/1ps
module dcps_field_model (
  input wire logic clk,
  input wire logic want_ao_current,
  input wire logic want_fb_current,
  input wire logic motor_run,
  output logic ao_switch,
  output logic fb_switch
);
  logic spinning_q;
  // Switches thrown by the installer; may disagree with the settings on purpose
  initial begin
    ao_switch = 1'b0;
    fb_switch = 1'b0;
  end
  always @(posedge clk) begin
    ao_switch <= want_ao_current;
    fb_switch <= want_fb_current;
    spinning_q <= motor_run;
  end
endmodule

/* File: bench/dcps_top_test.sv */
// Self-checking bench for the drive command block over its register port and pins.
// Assumes dcps_top, the field model and the port checker bound below.
`timescale 1ns/1ps
`include "dcps_defines.svh"
module dcps_top_test;
  logic CLOCK = 1'b0, RST = 1'b1, RUN_FWD = 1'b0, RUN_REV = 1'b0, WR = 1'b0, RD = 1'b0;
  logic [7:0] DIGITAL_INPUTS = 8'h00, ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000, RDATA, OUTPUT_FREQ, ANALOG_OUT_FIRST, ANALOG_OUT_SECOND, v;
  logic EMERGENCY_HALT_INDICATION, UNATTENDED_START_GUARD, MOTOR_RUN, MOTOR_REVERSE;
  logic ANALOG_OUT_SECOND_CURRENT, TYPE_MISMATCH, ao_sw, fb_sw;
  logic want_ao = 1'b0, want_fb = 1'b0;
  int miscompares = 0, num_checks = 0;
  logic [15:0] pid_mode [5] = '{16'h0001, 16'h0001, 16'h0003, 16'h0009, 16'h0000};
  logic [15:0] pid_kp [5] = '{16'h000A, 16'h0014, 16'h0014, 16'h000A, 16'h000A};
  logic [15:0] pid_exp [5] = '{16'h0080, 16'h0100, 16'h0000, 16'h0180, 16'h0000};
  always #25 CLOCK = ~CLOCK;
  dcps_field_model i_dcps_field_model (.clk(CLOCK), .want_ao_current(want_ao), .want_fb_current(want_fb),
    .motor_run(MOTOR_RUN), .ao_switch(ao_sw), .fb_switch(fb_sw));
  dcps_top i_dcps_top (.CLOCK(CLOCK), .RST(RST), .DIGITAL_INPUTS(DIGITAL_INPUTS), .RUN_FWD(RUN_FWD),
    .RUN_REV(RUN_REV), .ANALOG_OUT_TYPE_SWITCH(ao_sw), .FEEDBACK_TYPE_SWITCH(fb_sw), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EMERGENCY_HALT_INDICATION(EMERGENCY_HALT_INDICATION),
    .UNATTENDED_START_GUARD(UNATTENDED_START_GUARD), .MOTOR_RUN(MOTOR_RUN), .MOTOR_REVERSE(MOTOR_REVERSE),
    .OUTPUT_FREQ(OUTPUT_FREQ), .ANALOG_OUT_FIRST(ANALOG_OUT_FIRST), .ANALOG_OUT_SECOND(ANALOG_OUT_SECOND),
    .ANALOG_OUT_SECOND_CURRENT(ANALOG_OUT_SECOND_CURRENT), .TYPE_MISMATCH(TYPE_MISMATCH));
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles, waits and comparison
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge CLOCK);
    miscompares++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    wt(8);
    RST <= 1'b0;
    wt(1);
    chk({15'h0000, MOTOR_RUN}, 16'h0000);
    rd(`DCPS_OFS_HALT_TIME, v); chk(v, `DCPS_RST_HALT);
    rd(`DCPS_OFS_AO1_GAIN, v); chk(v, `DCPS_RST_GAIN);
    rd(`DCPS_OFS_PID_KP, v); chk(v, `DCPS_RST_KP);
    rd(`DCPS_OFS_PID_TI, v); chk(v, `DCPS_RST_TI);
    rd(8'hFF, v); chk(v, 16'h0000);
    // Jog inputs: forward on input five, reverse on input seven
    wr(`DCPS_OFS_DI_FUNC0 + 8'h05, {8'h00, `DCPS_FN_JOG_FWD});
    wr(`DCPS_OFS_DI_FUNC7, {8'h00, `DCPS_FN_JOG_REV});
    rd(`DCPS_OFS_DI_FUNC7, v); chk(v, {8'h00, `DCPS_FN_JOG_REV});
    DIGITAL_INPUTS <= 8'h20;
    wt(6); chk({14'h0000, MOTOR_RUN, MOTOR_REVERSE}, 16'h0002);
    DIGITAL_INPUTS <= 8'h80;
    wt(6); chk({14'h0000, MOTOR_RUN, MOTOR_REVERSE}, 16'h0003);
    DIGITAL_INPUTS <= 8'h00;
    wt(6);
    // Halt on input four with zero halt time, then the two exit conditions
    wr(`DCPS_OFS_DI_FUNC0 + 8'h04, {8'h00, `DCPS_FN_HALT});
    wr(`DCPS_OFS_HALT_TIME, 16'h0000);
    RUN_FWD <= 1'b1;
    wt(6); chk({15'h0000, MOTOR_RUN}, 16'h0001);
    DIGITAL_INPUTS <= 8'h10;
    wt(6); chk({15'h0000, EMERGENCY_HALT_INDICATION}, 16'h0001);
    chk(OUTPUT_FREQ, 16'h0000);
    DIGITAL_INPUTS <= 8'h20;
    wt(8); chk({15'h0000, EMERGENCY_HALT_INDICATION}, 16'h0001);
    chk({15'h0000, MOTOR_RUN}, 16'h0000);
    DIGITAL_INPUTS <= 8'h00;
    RUN_FWD <= 1'b0;
    wt(8); chk({15'h0000, EMERGENCY_HALT_INDICATION}, 16'h0000);
    // Regulator modes: gain, direction, target added, disabled
    wr(`DCPS_OFS_PID_TI, 16'hFFFF);
    wr(`DCPS_OFS_SETPOINT, 16'h0100);
    wr(`DCPS_OFS_FEEDBACK, 16'h0080);
    for (int i = 0; i < 5; i++) begin
      wr(`DCPS_OFS_PID_MODE, pid_mode[i]);
      wr(`DCPS_OFS_PID_KP, pid_kp[i]);
      wt(4);
      rd(`DCPS_OFS_PID_OUT, v); chk(v, pid_exp[i]);
    end
    rd(`DCPS_OFS_PID_MODE, v); chk(v, 16'h0000);
    // Analog outputs: full scale, reserved source, bias
    wr(`DCPS_OFS_SETPOINT, 16'h4000);
    wr(`DCPS_OFS_AO1_SRC, 16'h0017);
    wr(`DCPS_OFS_AO2_SRC, 16'h0017);
    wt(4); chk(ANALOG_OUT_FIRST, 16'hFFFF);
    chk(ANALOG_OUT_SECOND, 16'hFFFF);
    wr(`DCPS_OFS_AO1_SRC, 16'h000E);
    wt(4); chk(ANALOG_OUT_FIRST, 16'h0000);
    wr(`DCPS_OFS_AO1_BIAS, 16'h03E8);
    wt(4); chk(ANALOG_OUT_FIRST, 16'hFFFF);
    // Output and feedback types against the board switches
    wr(`DCPS_OFS_AO2_TYPE, 16'h0001);
    wt(6); chk({14'h0000, ANALOG_OUT_SECOND_CURRENT, TYPE_MISMATCH}, 16'h0003);
    want_ao = 1'b1;
    wt(6); chk({15'h0000, TYPE_MISMATCH}, 16'h0000);
    wr(`DCPS_OFS_FB_TYPE, {14'h0000, `DCPS_FB_CURR});
    wt(6); chk({15'h0000, TYPE_MISMATCH}, 16'h0001);
    want_fb = 1'b1;
    wt(6); chk({15'h0000, TYPE_MISMATCH}, 16'h0000);
    // Run request held through a power-up with the guard function set
    RUN_FWD <= 1'b1;
    RST <= 1'b1;
    wt(8);
    RST <= 1'b0;
    wr(`DCPS_OFS_DI_FUNC0, {8'h00, `DCPS_FN_GUARD});
    wt(6); chk({14'h0000, UNATTENDED_START_GUARD, MOTOR_RUN}, 16'h0002);
    RUN_FWD <= 1'b0;
    wt(6); chk({15'h0000, UNATTENDED_START_GUARD}, 16'h0000);
    end_sim();
  end
endmodule
bind dcps_top dcps_top_asserts i_dcps_top_asserts (.CLOCK(CLOCK), .RST(RST), .RUN_FWD(RUN_FWD),
  .RUN_REV(RUN_REV), .ANALOG_OUT_TYPE_SWITCH(ANALOG_OUT_TYPE_SWITCH), .RD(RD), .RDATA(RDATA),
  .EMERGENCY_HALT_INDICATION(EMERGENCY_HALT_INDICATION), .UNATTENDED_START_GUARD(UNATTENDED_START_GUARD),
  .MOTOR_RUN(MOTOR_RUN), .OUTPUT_FREQ(OUTPUT_FREQ), .ANALOG_OUT_SECOND_CURRENT(ANALOG_OUT_SECOND_CURRENT),
  .TYPE_MISMATCH(TYPE_MISMATCH));
